// ===== rtl/pio_top.sv
// The register addresses and the APB register port were decided locally.
`include "pio_defines.svh"

module pio_top #(
    parameter int unsigned TICK_CYCLES = `PIO_TICK_CYCLES
) (
    input  wire logic                   pclk,                   // control clock
    input  wire logic                   presetn,                // async reset, active low
    input  wire logic [`PIO_ADDR_W-1:0] paddr,                  // apb address
    input  wire logic                   psel,                   // apb select
    input  wire logic                   penable,                // apb enable
    input  wire logic                   pwrite,                 // apb write
    input  wire logic [31:0]            pwdata,                 // apb write data
    output      logic [31:0]            prdata,                 // apb read data
    output      logic                   pready,                 // apb ready
    output      logic                   pslverr,                // apb error
    input  wire logic                   loop_running,           // position loop operating
    input  wire logic                   encoder_vector_control, // closed-loop mode
    output      logic [`PIO_OUT_W-1:0]  inch_offset,            // offset q16.16 rev
    output      logic [`PIO_ACC_W-1:0]  inch_delta,             // step q16.48 rev
    output      logic                   inch_delta_valid,       // step pulse
    output      logic                   inch_active             // inch in progress
);
    import pio_pkg::*;

    // --------------------------------------------------------------
    // decoding and clamping helpers
    // --------------------------------------------------------------
    function automatic pio_reg_t decode_reg(input logic [`PIO_ADDR_W-1:0] a);
        case (a)
            `PIO_OFS_CTRL:   decode_reg = REG_CTRL;
            `PIO_OFS_RATE:   decode_reg = REG_RATE;
            `PIO_OFS_SCALE:  decode_reg = REG_SCALE;
            `PIO_OFS_OFFSET: decode_reg = REG_OFFSET;
            `PIO_OFS_STATUS: decode_reg = REG_STATUS;
            default:         decode_reg = REG_NONE;
        endcase
    endfunction

    // out-of-range writes saturate rather than fault, so a bad value
    // never stops the inch entirely
    function automatic logic [31:0] clamp32(input logic [31:0] v,
                                            input logic [31:0] lo,
                                            input logic [31:0] hi);
        if (v < lo) begin
            clamp32 = lo;
        end else if (v > hi) begin
            clamp32 = hi;
        end else begin
            clamp32 = v;
        end
    endfunction

    // --------------------------------------------------------------
    // declarations
    // --------------------------------------------------------------
    pio_acc_if acc_bus ();

    logic                     ctrl_adv;
    logic                     ctrl_ret;
    logic                     ctrl_rst;
    logic [`PIO_RATE_W-1:0]   rate_set;
    logic [`PIO_SCALE_W-1:0]  scale_set;
    logic [31:0]              tick_cnt;
    logic                     tick;
    pio_state_t               state;
    pio_state_t               next_state;
    pio_dir_t                 dir;
    pio_reg_t                 reg_sel;
    logic                     apb_acc;
    logic                     wr_en;
    logic [31:0]              rd_word;

    assign reg_sel = decode_reg(paddr);
    assign apb_acc = psel && penable;
    assign wr_en   = apb_acc && pready && pwrite;

    // --------------------------------------------------------------
    // apb slave: one wait state, answer on the second access cycle
    // --------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= apb_acc && !pready;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= apb_acc && !pready && (reg_sel == REG_NONE);
        end
    end

    always_comb begin
        rd_word = '0;
        unique case (reg_sel)
            REG_CTRL: begin
                rd_word[`PIO_CTRL_ADV] = ctrl_adv;
                rd_word[`PIO_CTRL_RET] = ctrl_ret;
                rd_word[`PIO_CTRL_RST] = ctrl_rst;
            end
            REG_RATE:   rd_word = 32'(rate_set);
            REG_SCALE:  rd_word = 32'(scale_set);
            REG_OFFSET: rd_word = inch_offset;
            REG_STATUS: begin
                rd_word[`PIO_ST_ACTIVE] = inch_active;
                rd_word[`PIO_ST_LOOP]   = loop_running;
                rd_word[`PIO_ST_MODE]   = encoder_vector_control;
                rd_word[`PIO_ST_FWD]    = (state == ST_ADVANCE);
                rd_word[`PIO_ST_BWD]    = (state == ST_RETARD);
            end
            REG_NONE:   rd_word = '0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
        end else if (apb_acc && !pready) begin
            prdata <= pwrite ? 32'h0000_0000 : rd_word;
        end
    end

    // --------------------------------------------------------------
    // control and settings registers
    // --------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_adv <= 1'b0;
            ctrl_ret <= 1'b0;
            ctrl_rst <= 1'b0;
        end else if (wr_en && reg_sel == REG_CTRL) begin
            ctrl_adv <= pwdata[`PIO_CTRL_ADV];
            ctrl_ret <= pwdata[`PIO_CTRL_RET];
            ctrl_rst <= pwdata[`PIO_CTRL_RST];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rate_set <= `PIO_RATE_RST;
        end else if (wr_en && reg_sel == REG_RATE) begin
            rate_set <= `PIO_RATE_W'(clamp32(pwdata, `PIO_RATE_MIN, `PIO_RATE_MAX));
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scale_set <= `PIO_SCALE_RST;
        end else if (wr_en && reg_sel == REG_SCALE) begin
            scale_set <= `PIO_SCALE_W'(clamp32(pwdata, `PIO_SCALE_MIN, `PIO_SCALE_MAX));
        end
    end

    // --------------------------------------------------------------
    // control sample tick
    // --------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_cnt <= '0;
            tick     <= 1'b0;
        end else begin
            tick <= (tick_cnt == 32'(TICK_CYCLES - 1));
            if (tick_cnt == 32'(TICK_CYCLES - 1)) begin
                tick_cnt <= '0;
            end else begin
                tick_cnt <= tick_cnt + 32'h0000_0001;
            end
        end
    end

    // --------------------------------------------------------------
    // inch direction state
    // --------------------------------------------------------------
    always_comb begin
        if (!encoder_vector_control) begin
            next_state = ST_IDLE;
        end else if (ctrl_adv && !ctrl_ret) begin
            next_state = ST_ADVANCE;
        end else if (ctrl_ret && !ctrl_adv) begin
            next_state = ST_RETARD;
        end else begin
            next_state = ST_IDLE;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            inch_active <= 1'b0;
        end else begin
            inch_active <= (next_state != ST_IDLE);
        end
    end

    // mode is gated again here so a mode drop stops the very next tick
    always_comb begin
        unique case (state)
            ST_ADVANCE: dir = encoder_vector_control ? PIO_FWD : PIO_HOLD;
            ST_RETARD:  dir = encoder_vector_control ? PIO_BWD : PIO_HOLD;
            ST_IDLE:    dir = PIO_HOLD;
            default:    dir = PIO_HOLD;
        endcase
    end

    // --------------------------------------------------------------
    // accumulator hookup
    // --------------------------------------------------------------
    assign acc_bus.tick  = tick;
    assign acc_bus.dir   = dir;
    assign acc_bus.clear = ctrl_rst && !loop_running;
    assign acc_bus.rate  = rate_set;
    assign acc_bus.scale = scale_set;

    pio_accum #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_accum (
        .pclk    (pclk),
        .presetn (presetn),
        .bus     (acc_bus.store)
    );

    assign inch_offset      = acc_bus.acc[`PIO_ACC_W-1:`PIO_ACC_W-`PIO_OUT_W];
    assign inch_delta       = acc_bus.delta;
    assign inch_delta_valid = acc_bus.delta_valid;

    // --------------------------------------------------------------
    // checks
    // --------------------------------------------------------------
    default clocking top_cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    apb_wait_a: assert property (apb_acc && !pready |=> pready)
        else $error("apb access not answered after one wait");
    apb_err_a: assert property (apb_acc && !pready && reg_sel == REG_NONE
        |=> pready && pslverr)
        else $error("unmapped address not flagged");
    reset_taken_a: assert property (ctrl_rst && !loop_running
        |=> inch_offset == '0)
        else $error("idle loop reset did not clear offset");
    reset_blocked_a: assert property (ctrl_rst && loop_running && !tick
        |=> $stable(acc_bus.acc))
        else $error("reset acted while loop running");
    rate_range_a: assert property (32'(rate_set) >= `PIO_RATE_MIN
        && 32'(rate_set) <= `PIO_RATE_MAX)
        else $error("rate setting out of range");
    scale_range_a: assert property (32'(scale_set) >= `PIO_SCALE_MIN
        && 32'(scale_set) <= `PIO_SCALE_MAX)
        else $error("rate scale out of range");
    offset_hold_a: assert property (state == ST_IDLE && !acc_bus.clear
        |=> $stable(inch_offset))
        else $error("offset drifted while not inching");
    active_on_a: assert property (encoder_vector_control && (ctrl_adv != ctrl_ret)
        |=> inch_active)
        else $error("active flag missing during inch");
    active_off_a: assert property (!encoder_vector_control || (ctrl_adv == ctrl_ret)
        |=> !inch_active)
        else $error("active flag set with no inch");
    // state lags the command by one edge, so the step gate closes one cycle later
    both_hold_a: assert property (ctrl_adv && ctrl_ret
        |=> ##1 !inch_delta_valid)
        else $error("step issued with both commands");
    mode_gate_a: assert property (!encoder_vector_control
        |=> !inch_delta_valid)
        else $error("step issued outside encoder vector mode");
    fwd_sign_a: assert property (tick && dir == PIO_FWD && !acc_bus.clear
        |=> inch_delta_valid && !inch_delta[`PIO_ACC_W-1])
        else $error("forward step not positive");
    bwd_sign_a: assert property (tick && dir == PIO_BWD && !acc_bus.clear
        |=> inch_delta_valid && inch_delta[`PIO_ACC_W-1])
        else $error("backward step not negative");
    tick_gap_a: assert property (tick |=> !tick [*2])
        else $error("sample ticks too close");

    fwd_inch_c:      cover property (tick && dir == PIO_FWD);
    bwd_inch_c:      cover property (tick && dir == PIO_BWD);
    both_cmd_c:      cover property (ctrl_adv && ctrl_ret && tick);
    reset_blocked_c: cover property (ctrl_rst && loop_running);
    bad_addr_c:      cover property (pready && pslverr);
endmodule

// ===== pkg/pio_defines.svh
`ifndef PIO_DEFINES_SVH
`define PIO_DEFINES_SVH

// ----------------------------------------------------------------------
// register map, byte addresses on the 32-bit apb bus
// ----------------------------------------------------------------------
`define PIO_ADDR_W      8
`define PIO_OFS_CTRL    8'h00
`define PIO_OFS_RATE    8'h04
`define PIO_OFS_SCALE   8'h08
`define PIO_OFS_OFFSET  8'h0C
`define PIO_OFS_STATUS  8'h10

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define PIO_CTRL_ADV    0
`define PIO_CTRL_RET    1
`define PIO_CTRL_RST    2
`define PIO_ST_ACTIVE   0
`define PIO_ST_LOOP     1
`define PIO_ST_MODE     2
`define PIO_ST_FWD      3
`define PIO_ST_BWD      4

// ----------------------------------------------------------------------
// settings: rate lsb 0.0001 rev/s, scale lsb 0.001
// ----------------------------------------------------------------------
`define PIO_RATE_W      19
`define PIO_RATE_MIN    32'h0000_0001
`define PIO_RATE_MAX    32'h0004_93E0
`define PIO_RATE_RST    19'h003E8
`define PIO_SCALE_W     15
`define PIO_SCALE_MIN   32'h0000_0001
`define PIO_SCALE_MAX   32'h0000_7530
`define PIO_SCALE_RST   15'h03E8
`define PIO_RATE_UNITS  64'd10000000

// ----------------------------------------------------------------------
// accumulator: signed q16.48 revolutions, offset out is q16.16
// ----------------------------------------------------------------------
`define PIO_ACC_W       64
`define PIO_FRAC_W      48
`define PIO_OUT_W       32

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define PIO_CLK_NS      8
`define PIO_CLK_HZ      64'd125000000
`define PIO_TICK_NS     250000
`define PIO_TICK_CYCLES (`PIO_TICK_NS / `PIO_CLK_NS)

`endif

// ===== pkg/pio_pkg.sv
package pio_pkg;
    typedef enum logic [1:0] {PIO_HOLD, PIO_FWD, PIO_BWD} pio_dir_t;
    typedef enum logic [1:0] {ST_IDLE, ST_ADVANCE, ST_RETARD} pio_state_t;
    typedef enum logic [2:0] {
        REG_CTRL, REG_RATE, REG_SCALE, REG_OFFSET, REG_STATUS, REG_NONE
    } pio_reg_t;
endpackage

// ===== pkg/pio_acc_if.sv
`include "pio_defines.svh"

interface pio_acc_if;
    import pio_pkg::*;
    logic                      tick;
    pio_dir_t                  dir;
    logic                      clear;
    logic [`PIO_RATE_W-1:0]    rate;
    logic [`PIO_SCALE_W-1:0]   scale;
    logic [`PIO_ACC_W-1:0]     acc;
    logic [`PIO_ACC_W-1:0]     delta;
    logic                      delta_valid;

    modport ctl (output tick, dir, clear, rate, scale, input acc, delta, delta_valid);
    modport store (input tick, dir, clear, rate, scale, output acc, delta, delta_valid);
endinterface

// ===== rtl/pio_accum.sv
`include "pio_defines.svh"

module pio_accum #(
    parameter int unsigned TICK_CYCLES = `PIO_TICK_CYCLES
) (
    input  wire logic  pclk,    // control clock
    input  wire logic  presetn, // async reset, active low
    pio_acc_if.store   bus      // step control and accumulator state
);
    import pio_pkg::*;

    // --------------------------------------------------------------
    // step size per sample tick, q16.48 revolutions
    // --------------------------------------------------------------
    // gain folds the 1e-7 rev/s product lsb and the tick period into
    // one constant so no divider is needed at run time
    localparam logic [63:0] STEP_GAIN =
        ((64'd1 << `PIO_FRAC_W) * 64'(TICK_CYCLES)) / (`PIO_RATE_UNITS * `PIO_CLK_HZ);

    logic [`PIO_ACC_W-1:0] step;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            step <= '0;
        end else begin
            step <= 64'(bus.rate) * 64'(bus.scale) * STEP_GAIN;
        end
    end

    // --------------------------------------------------------------
    // offset accumulator
    // --------------------------------------------------------------
    // wraps beyond +-32768 rev; far outside any useful inch distance
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus.acc <= '0;
        end else if (bus.clear) begin
            bus.acc <= '0;
        end else if (bus.tick) begin
            unique case (bus.dir)
                PIO_FWD:  bus.acc <= bus.acc + step;
                PIO_BWD:  bus.acc <= bus.acc - step;
                PIO_HOLD: bus.acc <= bus.acc;
                default:  bus.acc <= bus.acc;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus.delta       <= '0;
            bus.delta_valid <= 1'b0;
        end else begin
            bus.delta_valid <= bus.tick && !bus.clear && (bus.dir != PIO_HOLD);
            if (bus.tick && !bus.clear && bus.dir == PIO_FWD) begin
                bus.delta <= step;
            end else if (bus.tick && !bus.clear && bus.dir == PIO_BWD) begin
                bus.delta <= 64'(-step);
            end
        end
    end

    // --------------------------------------------------------------
    // checks
    // --------------------------------------------------------------
    default clocking acc_cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    fwd_step_a: assert property (bus.tick && !bus.clear && bus.dir == PIO_FWD
        |=> bus.acc == 64'($past(bus.acc) + $past(step)))
        else $error("forward tick did not add the step");
    bwd_step_a: assert property (bus.tick && !bus.clear && bus.dir == PIO_BWD
        |=> bus.acc == 64'($past(bus.acc) - $past(step)))
        else $error("backward tick did not subtract the step");
    hold_step_a: assert property (bus.tick && !bus.clear && bus.dir == PIO_HOLD
        |=> $stable(bus.acc))
        else $error("hold tick changed the offset");
    clear_zero_a: assert property (bus.clear |=> bus.acc == '0)
        else $error("clear did not zero the offset");
    tick_only_a: assert property (!bus.tick && !bus.clear |=> $stable(bus.acc))
        else $error("offset moved without a sample tick");
endmodule

// ===== tb/pio_loop_model.sv
`include "pio_defines.svh"

module pio_loop_model (
    input  wire logic                  pclk,                   // control clock
    input  wire logic                  presetn,                // async reset, active low
    input  wire logic [`PIO_ACC_W-1:0] inch_delta,             // step from the inch block
    input  wire logic                  inch_delta_valid,       // step pulse
    output      logic                  loop_running,           // position loop operating
    output      logic                  encoder_vector_control  // closed-loop mode
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [`PIO_ACC_W-1:0] pos_sum;

    initial begin
        loop_running = 1'b0;
        encoder_vector_control = 1'b1;
    end

    // ------------------------------------------------------------------
    // loop state, changed only right after a clock edge
    // ------------------------------------------------------------------
    task set_state(input logic run, input logic mode);
        loop_running <= run;
        encoder_vector_control <= mode;
    endtask

    // ------------------------------------------------------------------
    // error calculator: every step lands in the position sum
    // ------------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pos_sum <= '0;
        end else if (inch_delta_valid) begin
            pos_sum <= pos_sum + inch_delta;
        end
    end
endmodule

// ===== tb/tb_phase_inch_offset_generator.sv
`include "pio_defines.svh"

`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin miscompares++; \
    $display("[ERR] %0t got %0h exp %0h", $time, (got), (exp)); end end

module tb_phase_inch_offset_generator;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int     TC   = 100;
    localparam longint GAIN = 22; // floor(2^48*TC/1.25e15) for TC=100

    logic                  pclk;
    logic                  presetn;
    logic [7:0]            paddr;
    logic                  psel;
    logic                  penable;
    logic                  pwrite;
    logic [31:0]           pwdata;
    logic [31:0]           prdata;
    logic                  pready;
    logic                  pslverr;
    logic                  loop_running;
    logic                  encoder_vector_control;
    logic [31:0]           inch_offset;
    logic [63:0]           inch_delta;
    logic                  inch_delta_valid;
    logic                  inch_active;
    int                    miscompares = 0;
    int                    total_checks = 0;
    int                    cyc;
    int                    steps = 0;
    int                    m_dir = 0;
    longint                m_rate = 1000;
    longint                m_scale = 1000;
    logic signed [63:0]    m_acc = 0;
    logic signed [63:0]    m_tot = 0;
    logic [31:0]           seed = 32'h0000_5C82;

    pio_top #(.TICK_CYCLES(TC)) dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .loop_running(loop_running),
        .encoder_vector_control(encoder_vector_control), .inch_offset(inch_offset),
        .inch_delta(inch_delta), .inch_delta_valid(inch_delta_valid),
        .inch_active(inch_active));

    pio_loop_model u_loop (.pclk(pclk), .presetn(presetn), .inch_delta(inch_delta),
        .inch_delta_valid(inch_delta_valid), .loop_running(loop_running),
        .encoder_vector_control(encoder_vector_control));

    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) cyc <= 0;
        else cyc <= cyc + 1;
    end

    // ------------------------------------------------------------------
    // reference model: every step checked once it has landed
    // ------------------------------------------------------------------
    always @(negedge pclk) begin
        if (presetn && inch_delta_valid === 1'b1) begin
            m_acc = m_acc + m_dir * m_rate * m_scale * GAIN;
            m_tot = m_tot + m_dir * m_rate * m_scale * GAIN;
            steps++;
            `CHK(inch_delta, 64'(m_dir * m_rate * m_scale * GAIN))
            `CHK(inch_offset, m_acc[63:32])
        end
    end

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic test_done();
        if (miscompares == 0 && total_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // apb master; writes kept clear of the sample tick to avoid a race
    // ------------------------------------------------------------------
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        @(posedge pclk);
        if (wr) while (cyc % TC != 10) @(posedge pclk);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= wr;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // no cycle count assumed; only the watchdog ends a stuck wait
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, a, d, q, e);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic e_exp);
        logic [31:0] q;
        logic        e;
        apb(1'b0, a, 32'h0, q, e);
        `CHK(q, exp)
        `CHK(e, e_exp)
    endtask

    task automatic inch(input logic [31:0] c, input int d, input logic mode);
        int s0;
        m_rate = longint'(xs() % 300000) + 1;
        m_scale = longint'(xs() % 30000) + 1;
        wr(`PIO_OFS_RATE, 32'(m_rate));
        wr(`PIO_OFS_SCALE, 32'(m_scale));
        rd(`PIO_OFS_RATE, 32'(m_rate), 1'b0);
        u_loop.set_state(1'b0, mode);
        wr(`PIO_OFS_CTRL, c);
        m_dir = d;
        s0 = steps;
        repeat (3) @(posedge pclk);
        `CHK(inch_active, 1'(d != 0))
        rd(`PIO_OFS_STATUS, {27'h0, 1'(d < 0), 1'(d > 0), mode, 1'b0, 1'(d != 0)}, 1'b0);
        repeat (350) @(posedge pclk);
        `CHK(1'(steps - s0 > 2), 1'(d != 0))
        wr(`PIO_OFS_CTRL, 32'h0);
        m_dir = 0;
        u_loop.set_state(1'b0, 1'b1);
        repeat (3) @(posedge pclk);
        `CHK(inch_active, 1'b0)
        rd(`PIO_OFS_OFFSET, m_acc[63:32], 1'b0);
    endtask

    initial begin
        repeat (20000) @(posedge pclk);
        miscompares++;
        test_done();
    end

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        presetn = 1'b0;
        {paddr, psel, penable, pwrite, pwdata} = '0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rd(`PIO_OFS_RATE, 32'h0000_03E8, 1'b0);
        rd(`PIO_OFS_SCALE, 32'h0000_03E8, 1'b0);
        rd(`PIO_OFS_OFFSET, 32'h0, 1'b0);
        rd(8'h14, 32'h0, 1'b1);
        rd(`PIO_OFS_STATUS, 32'h0000_0004, 1'b0);
        wr(`PIO_OFS_RATE, 32'h0);
        rd(`PIO_OFS_RATE, 32'h0000_0001, 1'b0);
        wr(`PIO_OFS_RATE, 32'hFFFF_FFFF);
        rd(`PIO_OFS_RATE, 32'h0004_93E0, 1'b0);
        wr(`PIO_OFS_SCALE, 32'h0);
        rd(`PIO_OFS_SCALE, 32'h0000_0001, 1'b0);
        wr(`PIO_OFS_SCALE, 32'hFFFF_FFFF);
        rd(`PIO_OFS_SCALE, 32'h0000_7530, 1'b0);
        inch(32'h1, 1, 1'b1);
        inch(32'h2, -1, 1'b1);
        inch(32'h3, 0, 1'b1);
        inch(32'h1, 0, 1'b0);
        inch(32'h1, 1, 1'b1);
        // offset reset refused while the loop runs, honoured when idle
        u_loop.set_state(1'b1, 1'b1);
        wr(`PIO_OFS_CTRL, 32'h4);
        repeat (5) @(posedge pclk);
        rd(`PIO_OFS_OFFSET, m_acc[63:32], 1'b0);
        rd(`PIO_OFS_STATUS, 32'h0000_0006, 1'b0);
        wr(`PIO_OFS_CTRL, 32'h0);
        u_loop.set_state(1'b0, 1'b1);
        wr(`PIO_OFS_CTRL, 32'h4);
        m_acc = 0;
        repeat (3) @(posedge pclk);
        `CHK(inch_offset, 32'h0)
        wr(`PIO_OFS_CTRL, 32'h0);
        `CHK(u_loop.pos_sum, m_tot)
        test_done();
    end
endmodule
